// ==== hdl/sbu_branch_unit.sv ====
// Branch and loop execute logic of the 16-bit stack processor core.
// Assumes the core presents the advanced PC and pre-instruction register values
// each cycle, and applies the registered result one cycle after a valid branch.
// Overview of operation
// - The PC is split into a six-bit block number (bits 15-10) and a ten-bit offset.
// - Each branch is decided and its result produced in one clock cycle from the word, the advanced PC and the incoming register values.
// - A branch word has 100 on top, a condition field, a block selector and a nine-bit offset.
// - A taken branch loads the offset into PC bits 9-1 and clears PC bit 0.
// - Condition 00 branches when top is zero and leaves the parameter stack alone.
// - Condition 01 branches when top is zero and pops the parameter stack either way.
// - Condition 10 always branches and touches neither stack.
// - Condition 11 with a nonzero index decrements the index and branches together.
// - Selector 00 keeps the current block number.
// - Selector 01 adds one to the block number.
// - Selector 10 sets the block number to zero.
// - Selector 11 subtracts one from the block number.
// - The selector works on the already-advanced PC, the word after the branch.
// - Condition 11 with a zero index pops the return stack into the index and falls through.
`timescale 1ns/1ps
module sbu_branch_unit (
  input  wire logic               i_ref_clk,
  input  wire logic               i_reset,
  input  wire logic               i_valid,
  input  wire logic [15:0]        i_instr,
  input  wire logic [15:0]        i_pc_adv,
  input  wire sbu_pkg::sbu_regs_t i_regs,
  output logic                    o_is_branch,
  output logic                    o_done,
  output sbu_pkg::sbu_result_t    o_result
);

  sbu_pkg::sbu_instr_t  instr;
  sbu_pkg::sbu_result_t next_result;
  sbu_pkg::sbu_result_t result;
  logic                 next_done;
  logic                 done;
  logic                 is_branch;
  logic                 top_zero;
  logic                 index_zero;
  logic                 take;
  logic [15:0]          target;

  // Wraps inside the block field so a carry can never reach the code page
  function automatic logic [sbu_pkg::BLOCK_W-1:0] blk_step(
    input logic [sbu_pkg::BLOCK_W-1:0] blk,
    input sbu_pkg::sbu_blksel_t        sel
  );
    logic [sbu_pkg::BLOCK_W-1:0] r;
    r = blk;
    unique case (sel)
      sbu_pkg::SBU_BS_SAME: r = blk;
      sbu_pkg::SBU_BS_NEXT: r = sbu_pkg::BLOCK_W'(blk + sbu_pkg::BLOCK_ONE);
      sbu_pkg::SBU_BS_ZERO: r = sbu_pkg::BLOCK_ZERO;
      sbu_pkg::SBU_BS_PREV: r = sbu_pkg::BLOCK_W'(blk - sbu_pkg::BLOCK_ONE);
    endcase
    return r;
  endfunction

  assign instr      = sbu_pkg::sbu_instr_t'(i_instr);
  assign is_branch  = i_valid && (instr.opcode == sbu_pkg::OPC_BRANCH);
  // Compare the incoming pre-instruction values, never the updated ones
  assign top_zero   = (i_regs.top == sbu_pkg::WORD_ZERO);
  assign index_zero = (i_regs.index == sbu_pkg::WORD_ZERO);
  // Block from the advanced PC; offset fills bits 9-1 and bit 0 is cleared
  assign target = {blk_step(i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB],
                            instr.block_select_field),
                   instr.word_offset, 1'b0};
  assign o_is_branch = is_branch;

  always_comb begin
    next_result            = '0;
    next_result.pc_target  = target;
    next_result.new_top    = i_regs.top;
    next_result.new_second = i_regs.second;
    next_result.new_index  = i_regs.index;
    take                   = 1'b0;
    next_done              = is_branch;
    if (is_branch) begin
      unique case (instr.branch_cond_field)
        sbu_pkg::SBU_COND_TZERO_KEEP: begin
          take = top_zero;
        end
        sbu_pkg::SBU_COND_TZERO_POP: begin
          take                   = top_zero;
          next_result.pstack_pop = 1'b1;
          next_result.new_top    = i_regs.second;
          next_result.new_second = i_regs.pstack;
        end
        sbu_pkg::SBU_COND_ALWAYS: begin
          take = 1'b1;
        end
        sbu_pkg::SBU_COND_LOOP: begin
          if (!index_zero) begin
            take                   = 1'b1;
            next_result.index_load = 1'b1;
            next_result.new_index  = 16'(i_regs.index - sbu_pkg::WORD_ONE);
          end else begin
            next_result.index_load = 1'b1;
            next_result.rstack_pop = 1'b1;
            next_result.new_index  = i_regs.rstack;
          end
        end
      endcase
    end
    next_result.pc_load = take;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      result <= '0;
      done   <= 1'b0;
    end else begin
      result <= next_result;
      done   <= next_done;
    end
  end

  assign o_result = result;
  assign o_done   = done;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // Decode and timing: the core relies on done marking exactly the cycle after a branch
  chk_decode_opcode: assert property (
      i_valid && i_instr[sbu_pkg::WORD_W-1:sbu_pkg::OPC_LSB] == sbu_pkg::OPC_BRANCH
      |-> o_is_branch)
    else $error("branch opcode not decoded");

  chk_decode_valid: assert property (
      !i_valid
      |-> !o_is_branch)
    else $error("branch decoded without valid");

  chk_single_cycle_done: assert property (
      is_branch
      |=> o_done)
    else $error("branch result not ready after one cycle");

  chk_done_from_branch: assert property (
      o_done
      |-> $past(is_branch))
    else $error("done without a branch one cycle earlier");

  chk_idle_quiet: assert property (
      !is_branch
      |=> !o_done && !o_result.pc_load)
    else $error("action without branch");

  chk_idle_no_stack: assert property (
      !is_branch
      |=> !o_result.pstack_pop && !o_result.index_load && !o_result.rstack_pop)
    else $error("stack action without branch");

  // Target formation
  chk_align_bit_zero: assert property (
      o_result.pc_load
      |-> !o_result.pc_target[0])
    else $error("branch target not word aligned");

  chk_offset_field: assert property (
      is_branch
      |=> o_result.pc_target[sbu_pkg::BLOCK_LSB-1:0] == {$past(instr.word_offset), 1'b0})
    else $error("offset field wrong");

  chk_block_same: assert property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_SAME
      |=> o_result.pc_target[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] ==
          $past(i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB]))
    else $error("same block wrong");

  chk_block_next: assert property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_NEXT
      |=> o_result.pc_target[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == sbu_pkg::BLOCK_W'(
          $past(i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB]) + sbu_pkg::BLOCK_ONE))
    else $error("next block wrong");

  chk_block_zero: assert property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_ZERO
      |=> o_result.pc_target[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == sbu_pkg::BLOCK_ZERO)
    else $error("block zero wrong");

  chk_block_prev: assert property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_PREV
      |=> o_result.pc_target[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == sbu_pkg::BLOCK_W'(
          $past(i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB]) - sbu_pkg::BLOCK_ONE))
    else $error("prev block wrong");

  // A carry out of the block field would silently jump to another code page
  chk_next_wraps: assert property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_NEXT &&
      i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == ~sbu_pkg::BLOCK_ZERO
      |=> o_result.pc_target[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == sbu_pkg::BLOCK_ZERO)
    else $error("next block did not wrap to zero");

  chk_prev_wraps: assert property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_PREV &&
      i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == sbu_pkg::BLOCK_ZERO
      |=> o_result.pc_target[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == ~sbu_pkg::BLOCK_ZERO)
    else $error("previous block did not wrap to the top");

  // Condition field: decisions use the values held before the instruction
  chk_keep_no_pop: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_KEEP
      |=> !o_result.pstack_pop && o_result.pc_load == $past(top_zero))
    else $error("cond 00 wrong");

  chk_keep_regs_held: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_KEEP
      |=> o_result.new_top == $past(i_regs.top) && o_result.new_second == $past(i_regs.second))
    else $error("cond 00 changed the parameter stack");

  chk_keep_no_index: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_KEEP
      |=> !o_result.index_load && !o_result.rstack_pop)
    else $error("cond 00 touched the index");

  chk_keep_full_width: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_KEEP &&
      i_regs.top != sbu_pkg::WORD_ZERO
      |=> !o_result.pc_load)
    else $error("cond 00 branched on a nonzero top");

  chk_pop_always: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_POP
      |=> o_result.pstack_pop && o_result.new_top == $past(i_regs.second) &&
          o_result.pc_load == $past(top_zero))
    else $error("cond 01 wrong");

  chk_pop_second_fill: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_POP
      |=> o_result.new_second == $past(i_regs.pstack))
    else $error("cond 01 did not refill second");

  chk_pop_no_index: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_POP
      |=> !o_result.index_load && !o_result.rstack_pop)
    else $error("cond 01 touched the index");

  chk_pop_zero_taken: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_POP &&
      i_regs.top == sbu_pkg::WORD_ZERO
      |=> o_result.pc_load)
    else $error("cond 01 did not branch on a zero top");

  chk_pop_full_width: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_POP &&
      i_regs.top != sbu_pkg::WORD_ZERO
      |=> !o_result.pc_load && o_result.pstack_pop)
    else $error("cond 01 wrong with a nonzero top");

  chk_uncond_take: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_ALWAYS
      |=> o_result.pc_load && !o_result.rstack_pop && !o_result.pstack_pop)
    else $error("cond 10 wrong");

  chk_uncond_regs_held: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_ALWAYS
      |=> !o_result.index_load && o_result.new_top == $past(i_regs.top) &&
          o_result.new_second == $past(i_regs.second))
    else $error("cond 10 changed a stack");

  chk_loop_decrement: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP && !index_zero
      |=> o_result.pc_load && o_result.index_load &&
          o_result.new_index == 16'($past(i_regs.index) - sbu_pkg::WORD_ONE))
    else $error("loop decrement wrong");

  chk_loop_taken_stacks: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP && !index_zero
      |=> !o_result.rstack_pop && !o_result.pstack_pop)
    else $error("loop branch popped a stack");

  chk_loop_full_width: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP &&
      i_regs.index != sbu_pkg::WORD_ZERO
      |=> o_result.pc_load)
    else $error("loop did not branch on a nonzero index");

  chk_loop_exit: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP && index_zero
      |=> !o_result.pc_load && o_result.rstack_pop && o_result.index_load &&
          o_result.new_index == $past(i_regs.rstack))
    else $error("loop exit wrong");

  chk_loop_exit_stacks: assert property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP && index_zero
      |=> !o_result.pstack_pop)
    else $error("loop exit popped the parameter stack");

  chk_rpop_exit_only: assert property (
      o_result.rstack_pop
      |-> o_result.index_load && !o_result.pc_load)
    else $error("return pop outside a loop exit");

  // Main scenarios
  cov_loop_taken: cover property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP && !index_zero);
  cov_loop_exit: cover property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_LOOP && index_zero);
  cov_pop_not_taken: cover property (
      is_branch && instr.branch_cond_field == sbu_pkg::SBU_COND_TZERO_POP && !top_zero);
  cov_prev_wrap: cover property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_PREV &&
      i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == sbu_pkg::BLOCK_ZERO);
  cov_next_wrap: cover property (
      is_branch && instr.block_select_field == sbu_pkg::SBU_BS_NEXT &&
      i_pc_adv[sbu_pkg::BLOCK_MSB:sbu_pkg::BLOCK_LSB] == ~sbu_pkg::BLOCK_ZERO);

endmodule // sbu_branch_unit

// ==== hdl/sbu_pkg.sv ====
// Package for the stack processor branch unit: instruction fields, codes, widths.
// Assumes a 16-bit word machine with byte-addressed, word-aligned program counter.
package sbu_pkg;
  localparam int unsigned WORD_W    = 16;
  localparam int unsigned BLOCK_W   = 6;
  localparam int unsigned OFFSET_W  = 9;
  localparam int unsigned BLOCK_LSB = 10;
  localparam int unsigned BLOCK_MSB = 15;
  localparam int unsigned OPC_LSB   = 13;
  localparam logic [2:0]  OPC_BRANCH = 3'h4;
  localparam logic [BLOCK_W-1:0] BLOCK_ZERO = 6'h00;
  localparam logic [BLOCK_W-1:0] BLOCK_ONE  = 6'h01;
  localparam logic [WORD_W-1:0]  WORD_ZERO  = 16'h0000;
  localparam logic [WORD_W-1:0]  WORD_ONE   = 16'h0001;

  typedef enum logic [1:0] {
    SBU_COND_TZERO_KEEP = 2'h0,
    SBU_COND_TZERO_POP  = 2'h1,
    SBU_COND_ALWAYS     = 2'h2,
    SBU_COND_LOOP       = 2'h3
  } sbu_cond_t;

  typedef enum logic [1:0] {
    SBU_BS_SAME = 2'h0,
    SBU_BS_NEXT = 2'h1,
    SBU_BS_ZERO = 2'h2,
    SBU_BS_PREV = 2'h3
  } sbu_blksel_t;

  // Branch instruction word layout
  typedef struct packed {
    logic [2:0]          opcode;
    sbu_cond_t           branch_cond_field;
    sbu_blksel_t         block_select_field;
    logic [OFFSET_W-1:0] word_offset;
  } sbu_instr_t;

  // Stack and index values the core holds before the instruction
  typedef struct packed {
    logic [WORD_W-1:0] top;
    logic [WORD_W-1:0] second;
    logic [WORD_W-1:0] pstack;
    logic [WORD_W-1:0] index;
    logic [WORD_W-1:0] rstack;
  } sbu_regs_t;

  // Actions requested of the core for this cycle
  typedef struct packed {
    logic              pc_load;
    logic [WORD_W-1:0] pc_target;
    logic              pstack_pop;
    logic [WORD_W-1:0] new_top;
    logic [WORD_W-1:0] new_second;
    logic              index_load;
    logic [WORD_W-1:0] new_index;
    logic              rstack_pop;
  } sbu_result_t;
endpackage

// ==== testbench/tb_sbu_branch_unit.sv ====
// Self-checking bench for the branch unit: drives branch and non-branch words, checks results.
// Assumes the result registers one edge after the request and no stimulus during reset.
`timescale 1ns/1ps
module tb_sbu_branch_unit;
  logic                 i_ref_clk;
  logic                 i_reset;
  logic                 i_valid;
  logic [15:0]          i_instr;
  logic [15:0]          i_pc_adv;
  sbu_pkg::sbu_regs_t   i_regs;
  logic                 o_is_branch;
  logic                 o_done;
  sbu_pkg::sbu_result_t o_result;
  int                   miscompares     = 0;
  int                   samples_checked = 0;

  sbu_branch_unit u_sbu_branch_unit (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_valid(i_valid), .i_instr(i_instr),
    .i_pc_adv(i_pc_adv), .i_regs(i_regs), .o_is_branch(o_is_branch), .o_done(o_done),
    .o_result(o_result));

  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic check(input logic [67:0] seen, input logic [67:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  function automatic logic [15:0] target(input logic [15:0] instr, input logic [15:0] pc);
    logic [5:0] blk;
    case (instr[10:9])
      2'h0:    blk = pc[15:10];
      2'h1:    blk = pc[15:10] + 6'h01;
      2'h2:    blk = 6'h00;
      default: blk = pc[15:10] - 6'h01;
    endcase
    return {blk, instr[8:0], 1'b0};
  endfunction

  // Stack values differ from each other so a wrong source shows up at once
  task automatic run(input logic [15:0] instr, pc, top, idx, input logic vld);
    logic       br;
    logic       zi;
    logic       ld;
    logic [1:0] cond;
    cond = instr[12:11];
    br = vld && (instr[15:13] == 3'h4);
    zi = (idx == 16'h0000);
    ld = (cond == 2'h2) || (cond == 2'h3 ? !zi : top == 16'h0000);
    @(posedge i_ref_clk);
    i_valid  <= vld;
    i_instr  <= instr;
    i_pc_adv <= pc;
    i_regs   <= '{top, 16'h2222, 16'h3333, idx, 16'h5555};
    #1 check(o_is_branch, br, "decode");
    @(posedge i_ref_clk);
    i_valid <= 1'b0;
    #1 check(o_done, br, "done");
    check(o_result.pc_load, br && ld, "pc load");
    check({o_result.pstack_pop, o_result.index_load, o_result.rstack_pop},
          {br && cond == 2'h1, br && cond == 2'h3, br && cond == 2'h3 && zi},
          "flags");
    if (br) begin
      check(o_result.pc_target, target(instr, pc), "target");
      if (cond == 2'h1)
        check({o_result.new_top, o_result.new_second}, 32'h22223333, "pop");
      else
        check({o_result.new_top, o_result.new_second}, {top, 16'h2222}, "kept");
      if (cond == 2'h3)
        check(o_result.new_index, zi ? 16'h5555 : idx - 16'h0001, "index");
    end
  endtask

  // Every selector from the top block, block zero and a middle block, so both wraps appear
  task automatic test_selectors();
    logic [15:0] pcs [3] = '{16'hFC02, 16'h0002, 16'h14A6};
    for (int s = 0; s < 4; s++)
      foreach (pcs[p])
        run({5'h12, s[1:0], 9'h078}, pcs[p], 16'h0001, 16'h0001, 1'b1);
    $display("test_selectors done");
  endtask

  task automatic test_top_zero();
    logic [15:0] tops [3] = '{16'h0000, 16'h8000, 16'h0001};
    for (int c = 0; c < 2; c++)
      foreach (tops[t])
        run({3'h4, c[1:0], 2'h1, 9'h1FF}, 16'h0C00, tops[t], 16'h0000, 1'b1);
    $display("test_top_zero done");
  endtask

  task automatic test_loop();
    logic [15:0] idxs [4] = '{16'h0005, 16'h0000, 16'h8000, 16'h0001};
    foreach (idxs[k])
      run(16'h9E01, 16'h4402, 16'h0000, idxs[k], 1'b1);
    $display("test_loop done");
  endtask

  // Last word of a block, non-branch opcodes and a branch word without valid
  task automatic test_misc();
    run(16'h9055, 16'h0800, 16'h0007, 16'h0003, 1'b1);
    run(16'hB078, 16'h14A6, 16'h0000, 16'h0003, 1'b1);
    run(16'h1078, 16'h14A6, 16'h0000, 16'h0003, 1'b1);
    run(16'h9078, 16'h14A6, 16'h0000, 16'h0003, 1'b0);
    $display("test_misc done");
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // About 60 cycles of traffic; the limit leaves a wide margin
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end

  initial begin
    i_reset  = 1'b1;
    i_valid  = 1'b0;
    i_instr  = 16'h0000;
    i_pc_adv = 16'h0000;
    i_regs   = '0;
    repeat (8) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    test_selectors();
    test_top_zero();
    test_loop();
    test_misc();
    print_verdict();
  end
endmodule // tb_sbu_branch_unit
